// File: rtl/sac_pkg.sv
// package of register map, field layout and timing constants for the converter
package sac_pkg;
  // register word addresses on the apb bus
  localparam logic [11:0] CTRL_A_ADDR   = 12'h000;
  localparam logic [11:0] CTRL_B_ADDR   = 12'h004;
  localparam logic [11:0] RES_HIGH_ADDR = 12'h008;
  localparam logic [11:0] RES_LOW_ADDR  = 12'h00C;
  localparam logic [11:0] FLAG_ADDR     = 12'h010;
  localparam logic [11:0] IRQ_EN_ADDR   = 12'h014;
  localparam logic [11:0] SLEEP_ADDR    = 12'h018;
  // converter_control_a field positions
  localparam int A_POWER_BIT  = 0;
  localparam int A_GO_BIT     = 1;
  localparam int A_CHAN_LSB   = 2;
  localparam int A_REF_BIT    = 6;
  localparam int A_FORMAT_BIT = 7;
  // converter_control_b field position
  localparam int B_CLKSEL_LSB = 4;
  // flag and enable bit positions
  localparam int DONE_BIT     = 0;
  // sleep register: bit 0 sleeping, bit 1 global interrupt enable
  localparam int SLEEP_BIT    = 0;
  localparam int GIE_BIT      = 1;
  // reset values
  localparam logic [7:0] CTRL_A_RESET = 8'h00;
  localparam logic [7:0] CTRL_B_RESET = 8'h00;
  // conversion timing in conversion-clock periods
  localparam int CONV_PERIODS  = 11;
  localparam int ABORT_PERIODS = 2;
  localparam int RESULT_BITS   = 10;
  // internal oscillator period, ns, middle of the 2-6 us band
  localparam int    OSC_PERIOD_NS = 4000;
  localparam int    CLK_PERIOD_NS = 8;
  localparam int    OSC_HALF_CYC  = OSC_PERIOD_NS / CLK_PERIOD_NS / 2;
  // conversion clock select codes
  localparam logic [2:0] CS_DIV2  = 3'h0;
  localparam logic [2:0] CS_DIV4  = 3'h4;
  localparam logic [2:0] CS_DIV8  = 3'h1;
  localparam logic [2:0] CS_DIV16 = 3'h5;
  localparam logic [2:0] CS_DIV32 = 3'h2;
  localparam logic [2:0] CS_DIV64 = 3'h6;
endpackage

// File: rtl/sac_tick_if.sv
// interface carrying the conversion clock tick between modules
`timescale 1ns/1ps
`default_nettype none
interface sac_tick_if;
  logic [2:0] clk_select;
  logic       run;
  logic       tick;
  modport gen (input clk_select, input run, output tick);
  modport use_side (output clk_select, output run, input tick);
endinterface
`default_nettype wire

// File: rtl/sac_tick_gen.sv
// conversion clock period generator: system clock divider or oscillator
`timescale 1ns/1ps
`default_nettype none
module sac_tick_gen #(
  parameter int OSC_HALF = sac_pkg::OSC_HALF_CYC
) (
  input  wire logic clk,
  input  wire logic rstn,
  sac_tick_if.gen   tk
);
  typedef struct packed {
    logic [15:0] cnt;
  } sac_gen_t;
  sac_gen_t st, next_st;
  logic [15:0] limit;

  // ---------------------------------------------------------------
  // period select
  // ---------------------------------------------------------------
  // one tick per conversion-clock period; divider follows clk rate
  always_comb begin
    case (tk.clk_select)
      sac_pkg::CS_DIV2:  limit = 16'h0001; // see (R5) (R7)
      sac_pkg::CS_DIV4:  limit = 16'h0003;
      sac_pkg::CS_DIV8:  limit = 16'h0007;
      sac_pkg::CS_DIV16: limit = 16'h000F;
      sac_pkg::CS_DIV32: limit = 16'h001F;
      sac_pkg::CS_DIV64: limit = 16'h003F;
      // x11: internal oscillator, fixed period independent of clk
      default: limit = 16'((2 * OSC_HALF) - 1); // see (R8)
    endcase
  end

  // counter restarts while idle so the first period is whole
  always_comb begin
    next_st = st;
    if (!tk.run || st.cnt >= limit)
      next_st.cnt = 16'h0000;
    else
      next_st.cnt = st.cnt + 16'h0001;
  end

  assign tk.tick = tk.run && (st.cnt >= limit);

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn)
      st <= '0;
    else
      st <= next_st;
  end
endmodule
`default_nettype wire

// File: rtl/sac_top.sv
// control logic of the 10-bit successive-approximation converter
//
// Decided for this implementation: the APB register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// (R1) resolve 10-bit code, store in result pair
// (R2) channel field routes one input to sampler
// (R3) software waits settling time after channel change
// (R4) reference bit picks supply or external pin
// (R5) clock select codes map to divider or oscillator
// (R6) one bit per period, eleven periods total
// (R7) divider clocks follow system clock rate
// (R8) oscillator selection gives fixed period
// (R9) software picks clock meeting minimum period
// (R10) done flag set after every conversion
// (R11) hardware never clears done flag
// (R12) interrupt when flag and enable both set
// (R13) interrupt wakes device from sleep
// (R14) wake runs next instruction, vector if enabled
// (R15) format bit selects left or right justify
// (R16) software sets pin input and analog
// (R17) completion clears busy, sets flag, writes result
// (R18) early abort keeps result, two-period recovery
// (R19) justified placement across high and low registers
// (R20) channel code N selects input N
// (R21) busy bit reads one during conversion
module sac_top (
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        comp_high,
  output logic      [7:0]  channel_select,
  output logic             reference_select,
  output logic             sample_hold,
  output logic      [9:0]  dac_code,
  output logic             irq,
  output logic             wake,
  output logic             vector_to_handler
);
  typedef enum logic [3:0] {
    SAC_IDLE    = 4'b0001,
    SAC_CONVERT = 4'b0010,
    SAC_RECOVER = 4'b0100,
    SAC_SAMPLE  = 4'b1000
  } sac_state_t;

  typedef struct packed {
    sac_state_t  state;
    logic [7:0]  ctrl_a;
    logic [7:0]  ctrl_b;
    logic [9:0]  result;
    logic [9:0]  sar;
    logic [3:0]  step;
    logic        done_flag;
    logic        irq_en;
    logic        sleeping;
    logic        gie;
    logic [31:0] rdata;
  } sac_reg_t;

  sac_reg_t   st, next_st;
  sac_tick_if tk ();
  logic       wr_en, rd_en, go, mapped;

  sac_tick_gen u_tick (
    .clk  (clk),
    .rstn (rstn),
    .tk   (tk)
  );

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // justified high/low register images of a result
  function automatic logic [15:0] sac_pack(input logic [9:0] r,
                                           input logic right);
    if (right) // see (R15)
      sac_pack = {6'h00, r[9:8], r[7:0]};       // see (R19)
    else
      sac_pack = {r[9:2], r[1:0], 6'h00};       // see (R19)
  endfunction

  function automatic logic [7:0] sac_onehot(input logic [2:0] c);
    sac_onehot = 8'h01 << c;                    // see (R20)
  endfunction

  // ---------------------------------------------------------------
  // bus decode; zero wait states
  // ---------------------------------------------------------------
  always_comb begin
    case (paddr)
      sac_pkg::CTRL_A_ADDR, sac_pkg::CTRL_B_ADDR, sac_pkg::RES_HIGH_ADDR,
      sac_pkg::RES_LOW_ADDR, sac_pkg::FLAG_ADDR, sac_pkg::IRQ_EN_ADDR,
      sac_pkg::SLEEP_ADDR: mapped = 1'b1;
      default:             mapped = 1'b0;
    endcase
  end
  assign wr_en   = psel && penable && pwrite && mapped;
  assign rd_en   = psel && !penable && !pwrite;
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign prdata  = st.rdata;
  assign go      = st.ctrl_a[sac_pkg::A_GO_BIT]; // see (R21)

  // tick generator runs while converting or recovering
  assign tk.clk_select = st.ctrl_b[sac_pkg::B_CLKSEL_LSB +: 3];
  assign tk.run = (st.state == SAC_CONVERT) || (st.state == SAC_RECOVER);

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    logic [15:0] img;
    logic        fin;
    img     = sac_pack(st.result, st.ctrl_a[sac_pkg::A_FORMAT_BIT]);
    fin     = 1'b0;
    next_st = st;

    // register writes; read data latched in setup phase
    if (wr_en) begin
      case (paddr)
        sac_pkg::CTRL_A_ADDR:
          next_st.ctrl_a = pwdata[7:0] & 8'hDF; // bit 5 unused
        sac_pkg::CTRL_B_ADDR:
          next_st.ctrl_b = pwdata[7:0] & 8'h70;
        // software clears the flag by writing zero
        sac_pkg::FLAG_ADDR:
          next_st.done_flag = pwdata[sac_pkg::DONE_BIT];
        sac_pkg::IRQ_EN_ADDR:
          next_st.irq_en = pwdata[sac_pkg::DONE_BIT];
        sac_pkg::SLEEP_ADDR: begin
          next_st.sleeping = pwdata[sac_pkg::SLEEP_BIT];
          next_st.gie      = pwdata[sac_pkg::GIE_BIT];
        end
        default: ;
      endcase
    end

    // conversion sequence
    case (st.state)
      SAC_IDLE: begin
        if (go && st.ctrl_a[sac_pkg::A_POWER_BIT]) begin
          next_st.state = SAC_CONVERT;
          next_st.sar   = 10'h200;
          next_st.step  = 4'h0;
        end
      end
      SAC_CONVERT: begin
        if (!next_st.ctrl_a[sac_pkg::A_GO_BIT] ||
            !next_st.ctrl_a[sac_pkg::A_POWER_BIT]) begin
          // aborted: result untouched, wait two periods
          next_st.state = SAC_RECOVER;                 // see (R18)
          next_st.step  = 4'h0;
        end else if (tk.tick) begin
          // first period samples, then one bit per period
          if (st.step != 4'h0) begin                   // see (R6)
            if (!comp_high)
              next_st.sar[4'(10 - st.step)] = 1'b0;    // see (R1)
            if (st.step != 4'(sac_pkg::RESULT_BITS))
              next_st.sar[4'(9 - st.step)] = 1'b1;
          end
          next_st.step = st.step + 4'h1;
          if (st.step == 4'(sac_pkg::CONV_PERIODS - 1))
            fin = 1'b1;
        end
      end
      SAC_RECOVER: begin
        if (tk.tick) begin
          next_st.step = st.step + 4'h1;
          if (st.step == 4'(sac_pkg::ABORT_PERIODS - 1))
            next_st.state = SAC_SAMPLE;                // see (R18)
        end
      end
      SAC_SAMPLE: begin
        // acquisition restarts on the selected channel
        if (go && st.ctrl_a[sac_pkg::A_POWER_BIT])
          next_st.state = SAC_IDLE;
        else if (!st.ctrl_a[sac_pkg::A_POWER_BIT])
          next_st.state = SAC_IDLE;
      end
      default: next_st.state = SAC_IDLE;
    endcase

    // completion: busy clears, flag sets, result stored
    if (fin) begin
      next_st.state = SAC_IDLE;
      next_st.ctrl_a[sac_pkg::A_GO_BIT] = 1'b0;          // see (R17)
      next_st.result    = next_st.sar;                   // see (R17)
      next_st.done_flag = 1'b1;  // set wins over clear, see (R10) (R11)
    end

    // wake clears sleeping; handler entered only with global enable
    if (st.done_flag && st.irq_en && st.sleeping)
      next_st.sleeping = 1'b0;                           // see (R13)

    if (rd_en) begin
      case (paddr)
        sac_pkg::CTRL_A_ADDR:   next_st.rdata = {24'h0, st.ctrl_a};
        sac_pkg::CTRL_B_ADDR:   next_st.rdata = {24'h0, st.ctrl_b};
        sac_pkg::RES_HIGH_ADDR: next_st.rdata = {24'h0, img[15:8]};
        sac_pkg::RES_LOW_ADDR:  next_st.rdata = {24'h0, img[7:0]};
        sac_pkg::FLAG_ADDR:     next_st.rdata = {31'h0, st.done_flag};
        sac_pkg::IRQ_EN_ADDR:   next_st.rdata = {31'h0, st.irq_en};
        sac_pkg::SLEEP_ADDR:
          next_st.rdata = {30'h0, st.gie, st.sleeping};
        default:                next_st.rdata = 32'h0000_0000;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // analog side and interrupt outputs
  // ---------------------------------------------------------------
  assign channel_select =
    sac_onehot(st.ctrl_a[sac_pkg::A_CHAN_LSB +: 3]);     // see (R2)
  assign reference_select = st.ctrl_a[sac_pkg::A_REF_BIT]; // see (R4)
  assign sample_hold = (st.state == SAC_CONVERT);
  assign dac_code    = st.sar;
  assign irq = st.done_flag && st.irq_en;                // see (R12)
  assign wake = irq && st.sleeping;                      // see (R13)
  // one more instruction always runs; vector only with gie
  assign vector_to_handler = irq && st.gie;              // see (R14)

  // state register
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st        <= '0;
      st.state  <= SAC_IDLE;
      st.ctrl_a <= sac_pkg::CTRL_A_RESET;
      st.ctrl_b <= sac_pkg::CTRL_B_RESET;
    end else begin
      st <= next_st;
    end
  end
endmodule
`default_nettype wire

// File: tb/sac_analog.sv
// analog input pins and comparator facing the converter
`timescale 1ns/1ps
`default_nettype none
module sac_analog (
  input  wire logic [7:0][9:0] level,
  input  wire logic [7:0]      channel_select,
  input  wire logic            reference_select,
  input  wire logic [9:0]      dac_code,
  output logic                 comp_high
);
  logic [9:0] vin;
  // ----------------------------------------
  // input mux and comparator
  // ----------------------------------------
  // external reference pin is held at the supply level here, so one scale
  always_comb begin
    vin = 10'h000;
    for (int i = 0; i < 8; i++)
      if (channel_select[i]) vin = vin | level[i];
    comp_high = (vin >= dac_code);
  end
endmodule
`default_nettype wire

// File: tb/sac_properties.sv
// checker of converter port relations over time
`timescale 1ns/1ps
`default_nettype none
module sac_properties (
  input wire logic        clk,
  input wire logic        rstn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        comp_high,
  input wire logic [7:0]  channel_select,
  input wire logic        reference_select,
  input wire logic        sample_hold,
  input wire logic [9:0]  dac_code,
  input wire logic        irq,
  input wire logic        wake,
  input wire logic        vector_to_handler
);
  int unsigned busy_len;
  // ----------------------------------------
  // helper logic and properties
  // ----------------------------------------
  // length of the present conversion, too long for a repetition
  always_ff @(posedge clk or negedge rstn)
    if (!rstn) busy_len <= 0;
    else busy_len <= sample_hold ? busy_len + 1 : 0;
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  property p_onehot; $onehot(channel_select); endproperty
  a_onehot: assert property (p_onehot)
    else $error("channel not one-hot");
  property p_busy_min; $rose(sample_hold) |-> sample_hold [*8]; endproperty
  a_busy_min: assert property (p_busy_min)
    else $error("busy too short");
  property p_busy_max; busy_len < 5600; endproperty
  a_busy_max: assert property (p_busy_max)
    else $error("busy too long");
  property p_wake; wake |-> irq; endproperty
  a_wake: assert property (p_wake)
    else $error("wake without irq");
  property p_vec; vector_to_handler |-> irq; endproperty
  a_vec: assert property (p_vec)
    else $error("vector without irq");
  property p_keep; $fell(irq) |-> $past(psel && penable && pwrite); endproperty
  a_keep: assert property (p_keep)
    else $error("irq dropped alone");
  property p_raise;
    $rose(irq) |-> $past(psel && penable && pwrite) || $past(sample_hold);
  endproperty
  a_raise: assert property (p_raise)
    else $error("irq without cause");
  property p_ref;
    $changed(reference_select) |-> $past(psel && penable && pwrite);
  endproperty
  a_ref: assert property (p_ref)
    else $error("reference moved alone");
  property p_chan;
    $changed(channel_select) |-> $past(psel && penable && pwrite);
  endproperty
  a_chan: assert property (p_chan)
    else $error("channel moved alone");
  // approximation starts from the most significant trial bit
  property p_dac_start; $rose(sample_hold) |-> dac_code == 10'h200; endproperty
  a_dac_start: assert property (p_dac_start)
    else $error("first trial code not mid-scale");
  c_done: cover property ($fell(sample_hold));
  c_irq: cover property ($rose(irq));
  c_wake: cover property ($rose(wake));
endmodule
bind sac_top sac_properties sac_properties_inst (
  .clk(clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .comp_high(comp_high), .channel_select(channel_select),
  .reference_select(reference_select), .sample_hold(sample_hold),
  .dac_code(dac_code), .irq(irq), .wake(wake),
  .vector_to_handler(vector_to_handler));
`default_nettype wire

// File: tb/tb.sv
// self-checking bench of the converter control block
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clk, rstn, psel, penable, pwrite, comp_high, pready, pslverr;
  logic reference_select, sample_hold, irq, wake, vector_to_handler;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rnd;
  logic [7:0] channel_select;
  logic [9:0] dac_code;
  logic [7:0][9:0] level;
  logic seen_wake;
  int num_errors, cmp_count, hl, last_len;
  sac_top sac_top_inst (.clk(clk), .rstn(rstn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .comp_high(comp_high), .channel_select(channel_select),
    .reference_select(reference_select), .sample_hold(sample_hold),
    .dac_code(dac_code), .irq(irq), .wake(wake),
    .vector_to_handler(vector_to_handler));
  sac_analog sac_analog_inst (.level(level), .channel_select(channel_select),
    .reference_select(reference_select), .dac_code(dac_code),
    .comp_high(comp_high));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    lfsr = {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  // conversion clock period in system cycles for each select code
  function automatic int per(input logic [2:0] cs);
    case (cs)
      3'h0: per = 2;
      3'h4: per = 4;
      3'h1: per = 8;
      3'h5: per = 16;
      3'h2: per = 32;
      3'h6: per = 64;
      default: per = 2 * sac_pkg::OSC_HALF_CYC;
    endcase
  endfunction
  // high byte then low byte of the justified result
  function automatic logic [15:0] fmt(input logic f, input logic [9:0] v);
    fmt = f ? {6'h00, v} : {v, 6'h00};
  endfunction
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  // one apb transfer, entered just after a rising edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      num_errors++;
      test_done();
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] q);
    logic e;
    apb(1'b0, a, 32'h0, q, e);
  endtask
  // ----------------------------------------
  // clock and monitors
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // busy length and wake pulses are short, so latch them here
  // cleared here during reset so only this process drives them
  always @(posedge clk) begin
    if (!rstn) begin
      hl <= 0;
      last_len <= 0;
      seen_wake <= 1'b0;
    end else begin
      if (sample_hold === 1'b1) hl <= hl + 1;
      else if (hl != 0) begin
        last_len <= hl;
        hl <= 0;
      end
      if (wake === 1'b1) seen_wake <= 1'b1;
    end
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    logic [31:0] q;
    logic e, rf, f;
    logic [2:0] cs, ch;
    logic [9:0] v;
    logic [2:0] cs_tab [8];
    int n;
    cs_tab = '{3'h0, 3'h4, 3'h1, 3'h5, 3'h2, 3'h6, 3'h3, 3'h7};
    {rstn, psel, penable, pwrite, paddr, pwdata} = '0;
    num_errors = 0;
    cmp_count = 0;
    level = '0;
    rnd = 32'h0FB42CC9;
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    chk("channel at reset", 32'h1, {24'h0, channel_select});
    rd(sac_pkg::CTRL_A_ADDR, q);
    chk("ctrl_a reset", 32'h0, q);
    apb(1'b0, 12'h01C, 32'h0, q, e);
    chk("unmapped data", 32'h0, q);
    chk("unmapped error", 32'h1, {31'h0, e});
    wr(sac_pkg::IRQ_EN_ADDR, 32'h1);
    for (int i = 0; i < 8; i++) begin
      rnd = lfsr(rnd);
      {v, f, rf, ch} = rnd[14:0];
      cs = cs_tab[i];
      if (i == 0) v = 10'h3FF;
      if (i == 1) v = 10'h000;
      // every format and reference pairing appears at least once
      if (i < 4) {f, rf} = 2'(i);
      level[ch] <= v;
      if (i == 7) wr(sac_pkg::SLEEP_ADDR, 32'h1);
      wr(sac_pkg::CTRL_B_ADDR, {25'h0, cs, 4'h0});
      wr(sac_pkg::CTRL_A_ADDR, {24'h0, f, rf, 1'b0, ch, 2'b01});
      chk("channel", 32'h1 << ch, {24'h0, channel_select});
      chk("reference", {31'h0, rf}, {31'h0, reference_select});
      repeat (20) @(posedge clk);
      wr(sac_pkg::CTRL_A_ADDR, {24'h0, f, rf, 1'b0, ch, 2'b11});
      rd(sac_pkg::CTRL_A_ADDR, q);
      chk("busy bit", 32'h1, {31'h0, q[1]});
      n = 0;
      do begin
        rd(sac_pkg::CTRL_A_ADDR, q);
        n++;
      end while (q[1] === 1'b1 && n < 3000);
      if (n >= 3000) begin
        num_errors++;
        test_done();
      end
      n = per(cs);
      // exactly eleven periods of the selected conversion clock
      chk("length", 32'(sac_pkg::CONV_PERIODS * n), 32'(last_len));
      rd(sac_pkg::FLAG_ADDR, q);
      chk("done flag", 32'h1, q);
      rd(sac_pkg::RES_HIGH_ADDR, q);
      chk("result high", {16'h0, fmt(f, v) >> 8}, q);
      rd(sac_pkg::RES_LOW_ADDR, q);
      chk("result low", {16'h0, fmt(f, v) & 16'h00FF}, q);
      chk("irq set", 32'h1, {31'h0, irq});
      if (i == 7) begin
        chk("wake seen", 32'h1, {31'h0, seen_wake});
        rd(sac_pkg::SLEEP_ADDR, q);
        chk("sleep cleared", 32'h0, q);
      end
      wr(sac_pkg::IRQ_EN_ADDR, 32'h0);
      chk("irq masked", 32'h0, {31'h0, irq});
      wr(sac_pkg::IRQ_EN_ADDR, 32'h1);
      chk("irq held", 32'h1, {31'h0, irq});
      wr(sac_pkg::FLAG_ADDR, 32'h0);
      chk("irq cleared", 32'h0, {31'h0, irq});
    end
    // gie steers a pending request to the handler
    wr(sac_pkg::SLEEP_ADDR, 32'h2);
    wr(sac_pkg::FLAG_ADDR, 32'h1);
    chk("vector on", 32'h1, {31'h0, vector_to_handler});
    wr(sac_pkg::SLEEP_ADDR, 32'h0);
    chk("vector off", 32'h0, {31'h0, vector_to_handler});
    wr(sac_pkg::FLAG_ADDR, 32'h0);
    // abort within the first (sampling) period: old result stays, no flag
    level[ch] <= ~v;
    wr(sac_pkg::CTRL_B_ADDR, {25'h0, 3'h6, 4'h0});
    wr(sac_pkg::CTRL_A_ADDR, {24'h0, f, rf, 1'b0, ch, 2'b11});
    repeat (40) @(posedge clk);
    wr(sac_pkg::CTRL_A_ADDR, {24'h0, f, rf, 1'b0, ch, 2'b01});
    // wait past a full /64 conversion so a missed abort would show
    repeat (800) @(posedge clk);
    chk("idle after abort", 32'h0, {31'h0, sample_hold});
    rd(sac_pkg::RES_HIGH_ADDR, q);
    chk("kept high", {16'h0, fmt(f, v) >> 8}, q);
    rd(sac_pkg::RES_LOW_ADDR, q);
    chk("kept low", {16'h0, fmt(f, v) & 16'h00FF}, q);
    rd(sac_pkg::FLAG_ADDR, q);
    chk("no flag", 32'h0, q);
    test_done();
  end
endmodule
`default_nettype wire
